//--- design/esc_pkg.sv
// Package with register map, field layout and sizes of the statistics counter block
package esc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned ADDR_W  = 8;   // Byte address width
  localparam int unsigned DATA_W  = 32;  // Bus data width
  localparam int unsigned CNT_W   = 16;  // Counter width
  localparam int unsigned NUM_CNT = 6;   // Number of counters
  localparam int unsigned COLL_W  = 4;   // Collision count width

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_RX_DROP   = 8'h00;  // rx_overflow_drop_count
  localparam logic [ADDR_W-1:0] OFF_TX_OK     = 8'h04;  // tx_frames_ok_count
  localparam logic [ADDR_W-1:0] OFF_SCOL      = 8'h08;  // single_collision_frame_count
  localparam logic [ADDR_W-1:0] OFF_MCOL      = 8'h0C;  // multi_collision_frame_count
  localparam logic [ADDR_W-1:0] OFF_RX_OK     = 8'h10;  // rx_frames_ok_count
  localparam logic [ADDR_W-1:0] OFF_FCS_ERR   = 8'h14;  // rx_fcs_error_count
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 8'h18;  // interrupt_request_reg
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h1C;  // Interrupt mask

  // ****************************************************************
  // Event bit positions (counter index and status bit)
  // ****************************************************************
  localparam int unsigned EV_RX_DROP = 0;  // Also rx_fifo_overflow_flag
  localparam int unsigned EV_TX_OK   = 1;
  localparam int unsigned EV_SCOL    = 2;
  localparam int unsigned EV_MCOL    = 3;
  localparam int unsigned EV_RX_OK   = 4;
  localparam int unsigned EV_FCS_ERR = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0]   RST_CNT  = 16'h0000;
  localparam logic [NUM_CNT-1:0] RST_STAT = 6'h00;
  localparam logic [NUM_CNT-1:0] RST_MASK = 6'h00;

endpackage

//--- design/esc_event_decode.sv
// Turns MAC transmit and receive status into one-cycle counting events
`timescale 1ns/100ps
`default_nettype none
module esc_event_decode
  import esc_pkg::*;
#(
  parameter int unsigned CW = COLL_W  // Collision count width
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Transmit status
  input  wire logic               tx_done_i,
  input  wire logic               tx_ok_i,
  input  wire logic [CW-1:0]      tx_coll_i,
  // Receive status
  input  wire logic               rx_done_i,
  input  wire logic               rx_accept_i,
  input  wire logic               rx_overrun_i,
  input  wire logic               rx_fcs_err_i,
  input  wire logic [2:0]         rx_len_bits_i,
  // Events
  output logic [NUM_CNT-1:0]      ev_o
);

  logic [NUM_CNT-1:0] ev_next;  // Combined events
  logic               tx_good;  // Frame sent
  logic               rx_whole; // Length in whole bytes

  // ****************************************************************
  // Event decode
  // ****************************************************************
  always_comb begin
    tx_good  = tx_done_i & tx_ok_i;
    rx_whole = (rx_len_bits_i == 3'h0);
    ev_next  = '0;
    ev_next[EV_RX_DROP] = rx_done_i & rx_accept_i & rx_overrun_i;
    ev_next[EV_TX_OK]   = tx_good;
    ev_next[EV_SCOL]    = tx_good & (tx_coll_i == CW'(1));
    ev_next[EV_MCOL]    = tx_good & (tx_coll_i > CW'(1));
    ev_next[EV_RX_OK]   = rx_done_i & rx_accept_i & ~rx_overrun_i & ~rx_fcs_err_i;
    ev_next[EV_FCS_ERR] = rx_done_i & rx_fcs_err_i & rx_whole;
  end

  // Registered pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_o <= '0;
    end else begin
      ev_o <= ev_next;
    end
  end

endmodule
`default_nettype wire

//--- design/esc_counter.sv
// One clear-on-read statistics counter with debug write
`timescale 1ns/100ps
`default_nettype none
module esc_counter
  import esc_pkg::*;
#(
  parameter int unsigned W = CNT_W  // Counter width
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Control
  input  wire logic          inc_i,
  input  wire logic          clr_i,
  input  wire logic          wr_i,
  input  wire logic [W-1:0]  wr_data_i,
  // Count
  output logic [W-1:0]       count_o
);

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= W'(RST_CNT);
    end else if (wr_i) begin
      // Debug write
      count_o <= wr_data_i;
    end else if (inc_i && clr_i) begin
      count_o <= W'(1);
    end else if (inc_i) begin
      count_o <= count_o + W'(1);
    end else if (clr_i) begin
      count_o <= '0;
    end
  end

endmodule
`default_nettype wire

//--- design/esc_stat_counters.sv
// Top of the Ethernet frame statistics counter bank
//
// Functional notes
// - Count accepted frames dropped on overrun
// - Overrun drop also sets overflow flag
// - Count successfully transmitted frames
// - Count frames sent after one collision
// - Count frames sent after several collisions
// - Count successfully received frames
// - No receive count on FCS/alignment error
// - FCS count only for whole-byte frames
// - Read clears counter unless bytes 0/1 off
// - Bits 31 to 16 read zero
// - Alignment errors kept out of FCS count
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module esc_stat_counters (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         arst_n_i,
  // Register port
  input  wire logic [esc_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [esc_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic [3:0]                   be_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic [esc_pkg::DATA_W-1:0]        rdata_o,
  // Transmit status
  input  wire logic                         tx_done_i,
  input  wire logic                         tx_ok_i,
  input  wire logic [esc_pkg::COLL_W-1:0]   tx_coll_i,
  // Receive status
  input  wire logic                         rx_done_i,
  input  wire logic                         rx_accept_i,
  input  wire logic                         rx_overrun_i,
  input  wire logic                         rx_fcs_err_i,
  input  wire logic [2:0]                   rx_len_bits_i,
  // Interrupt
  output logic                              irq_o
);
  import esc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0]            rst_sync_reg;  // Reset release chain
  logic                  rst_n;         // Synchronised reset
  logic [NUM_CNT-1:0]    ev;            // Counting events
  logic [NUM_CNT-1:0]    cnt_clr;       // Clear-on-read strobes
  logic [NUM_CNT-1:0]    cnt_wr;        // Debug write strobes
  logic [CNT_W-1:0]      count [NUM_CNT];  // Counter values
  logic [NUM_CNT-1:0]    irq_stat_reg;  // Sticky event flags
  logic [NUM_CNT-1:0]    irq_stat_next; // Next flags
  logic [NUM_CNT-1:0]    irq_mask_reg;  // Interrupt enables
  logic [DATA_W-1:0]     rdata_next;    // Read mux
  logic                  low_be;        // Byte 0 or 1 enabled
  logic [CNT_W-1:0]      wr_val;        // Write data for counters
  int                    sel;           // Decoded counter index

  // Counter index of an address, or -1 when not a counter
  function automatic int cnt_index(input logic [ADDR_W-1:0] a);
    int idx;
    idx = -1;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (a == ADDR_W'(OFF_RX_DROP + 4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Event decode
  // ****************************************************************
  esc_event_decode #(
    .CW (COLL_W)
  ) u_decode (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n),
    .tx_done_i     (tx_done_i),
    .tx_ok_i       (tx_ok_i),
    .tx_coll_i     (tx_coll_i),
    .rx_done_i     (rx_done_i),
    .rx_accept_i   (rx_accept_i),
    .rx_overrun_i  (rx_overrun_i),
    .rx_fcs_err_i  (rx_fcs_err_i),
    .rx_len_bits_i (rx_len_bits_i),
    .ev_o          (ev)
  );

  // ****************************************************************
  // Access decode
  // ****************************************************************
  always_comb begin
    sel     = cnt_index(addr_i);
    low_be  = be_i[0] | be_i[1];
    wr_val  = wdata_i[CNT_W-1:0];
    cnt_clr = '0;
    cnt_wr  = '0;
    if (sel >= 0) begin
      cnt_clr[sel] = rd_i & low_be;
      cnt_wr[sel]  = wr_i;
    end
  end

  // ****************************************************************
  // Counter bank
  // ****************************************************************
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    esc_counter #(
      .W (CNT_W)
    ) u_cnt (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .inc_i     (ev[g]),
      .clr_i     (cnt_clr[g]),
      .wr_i      (cnt_wr[g]),
      .wr_data_i (wr_val),
      .count_o   (count[g])
    );
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_i && addr_i == OFF_IRQ_STAT) begin
      // Write one to clear
      irq_stat_next = irq_stat_next & ~wdata_i[NUM_CNT-1:0];
    end
    // events set flags, set beats clear
    irq_stat_next = irq_stat_next | ev;
  end

  // Status flags
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= RST_STAT;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Mask register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= RST_MASK;
    end else if (wr_i && addr_i == OFF_IRQ_MASK) begin
      irq_mask_reg <= wdata_i[NUM_CNT-1:0];
    end
  end

  // Interrupt line from flags already set
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_next = '0;
    if (rd_i) begin
      if (sel >= 0) begin
        rdata_next = DATA_W'(count[sel]);
      end else if (addr_i == OFF_IRQ_STAT) begin
        rdata_next = DATA_W'(irq_stat_reg);
      end else if (addr_i == OFF_IRQ_MASK) begin
        rdata_next = DATA_W'(irq_mask_reg);
      end
    end
  end

  // Read data stands one cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // drop counter advances
  property p_drop_inc;
    @(posedge clk_i) disable iff (!rst_n)
      (ev[EV_RX_DROP] && !cnt_clr[EV_RX_DROP] && !cnt_wr[EV_RX_DROP])
      |=> count[EV_RX_DROP] == $past(count[EV_RX_DROP]) + 16'h0001;
  endproperty
  a_drop_inc: assert property (p_drop_inc) else $error("drop count not advanced");

  property p_ovf_flag;
    @(posedge clk_i) disable iff (!rst_n)
      (ev[EV_RX_DROP] && irq_mask_reg[EV_RX_DROP])
      |=> irq_stat_reg[EV_RX_DROP] ##1 irq_o;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag or irq missing");

  // transmit success raises its event one cycle on
  property p_tx_ok;
    @(posedge clk_i) disable iff (!rst_n)
      (tx_done_i && tx_ok_i) |=> ev[EV_TX_OK];
  endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("tx ok event missing");

  property p_scol;
    @(posedge clk_i) disable iff (!rst_n)
      (tx_done_i && tx_ok_i) |=> (ev[EV_SCOL] == ($past(tx_coll_i) == 4'h1));
  endproperty
  a_scol: assert property (p_scol) else $error("single collision decode wrong");

  property p_mcol;
    @(posedge clk_i) disable iff (!rst_n)
      (tx_done_i && tx_ok_i) |=> (ev[EV_MCOL] == ($past(tx_coll_i) > 4'h1));
  endproperty
  a_mcol: assert property (p_mcol) else $error("multi collision decode wrong");

  property p_rx_ok;
    @(posedge clk_i) disable iff (!rst_n)
      (rx_done_i && rx_accept_i && !rx_overrun_i && !rx_fcs_err_i) |=> ev[EV_RX_OK];
  endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("rx ok event missing");

  property p_rx_err;
    @(posedge clk_i) disable iff (!rst_n)
      (rx_done_i && rx_fcs_err_i) |=> !ev[EV_RX_OK];
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("errored frame counted good");

  property p_fcs;
    @(posedge clk_i) disable iff (!rst_n)
      (rx_done_i && rx_fcs_err_i && rx_len_bits_i == 3'h0) |=> ev[EV_FCS_ERR];
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs event missing");

  // alignment error not counted as FCS
  property p_align;
    @(posedge clk_i) disable iff (!rst_n)
      (rx_done_i && rx_len_bits_i != 3'h0) |=> !ev[EV_FCS_ERR];
  endproperty
  a_align: assert property (p_align) else $error("alignment error counted as fcs");

  property p_rd_clr;
    @(posedge clk_i) disable iff (!rst_n)
      (cnt_clr[EV_RX_OK] && !ev[EV_RX_OK]) |=> count[EV_RX_OK] == 16'h0000;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("read did not clear");

  property p_upper;
    @(posedge clk_i) disable iff (!rst_n)
      rd_i |=> rdata_o[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");

  // event during clearing read leaves one
  property p_keep;
    @(posedge clk_i) disable iff (!rst_n)
      (cnt_clr[EV_TX_OK] && ev[EV_TX_OK] && !cnt_wr[EV_TX_OK]) |=> count[EV_TX_OK] == 16'h0001;
  endproperty
  a_keep: assert property (p_keep) else $error("event lost on clear");

  // Main scenarios
  property p_cov_read;
    @(posedge clk_i) disable iff (!rst_n) (rd_i && sel >= 0 && count[sel] != 16'h0000);
  endproperty
  c_cov_read: cover property (p_cov_read);

  property p_cov_keep;
    @(posedge clk_i) disable iff (!rst_n) (|(cnt_clr & ev));
  endproperty
  c_cov_keep: cover property (p_cov_keep);

  property p_cov_irq;
    @(posedge clk_i) disable iff (!rst_n) $rose(irq_o);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

endmodule
`default_nettype wire

//--- dv/esc_mac_model.sv
// Behavioural model of the MAC transmit and receive status logic
`timescale 1ns/100ps
`default_nettype none
module esc_mac_model
  import esc_pkg::*;
(
  // Clock
  input  wire logic                  clk_i,
  // Transmit status
  output var logic                   tx_done_o,
  output var logic                   tx_ok_o,
  output var logic [COLL_W-1:0]      tx_coll_o,
  // Receive status
  output var logic                   rx_done_o,
  output var logic                   rx_accept_o,
  output var logic                   rx_overrun_o,
  output var logic                   rx_fcs_err_o,
  output var logic [2:0]             rx_len_bits_o
);
  logic              q_tx, q_ok, q_rx, q_acc, q_ovr, q_fcs;  // Staged requests
  logic [COLL_W-1:0] q_coll;                                 // Staged collisions
  logic [2:0]        q_len;                                  // Staged dribble bits
  logic [3:0]        junk;                                   // Changing idle pattern

  initial begin
    {q_tx, q_ok, q_rx, q_acc, q_ovr, q_fcs, q_coll, q_len, junk} = '0;
    {tx_done_o, tx_ok_o, tx_coll_o, rx_done_o} = '0;
    {rx_accept_o, rx_overrun_o, rx_fcs_err_o, rx_len_bits_o} = '0;
  end

  // ****************************************************************
  // Drive pins; qualifiers carry garbage outside a done pulse
  // ****************************************************************
  always @(posedge clk_i) begin
    junk          <= junk + 4'h5;
    tx_done_o     <= q_tx;
    tx_ok_o       <= q_tx ? q_ok : junk[0];
    tx_coll_o     <= q_tx ? q_coll : ~junk;
    rx_done_o     <= q_rx;
    rx_accept_o   <= q_rx ? q_acc : junk[1];
    rx_overrun_o  <= q_rx ? q_ovr : ~junk[1];
    rx_fcs_err_o  <= q_rx ? q_fcs : junk[2];
    rx_len_bits_o <= q_rx ? q_len : junk[3:1];
  end

  // One transmit status pulse
  task automatic tx(input logic ok, input logic [COLL_W-1:0] coll);
    @(negedge clk_i);
    q_tx = 1'b1;
    q_ok = ok;
    q_coll = coll;
    @(negedge clk_i);
    q_tx = 1'b0;
  endtask

  // One receive status pulse
  task automatic rx(input logic acc, input logic ovr, input logic fcs, input logic [2:0] len);
    @(negedge clk_i);
    q_rx = 1'b1;
    {q_acc, q_ovr, q_fcs, q_len} = {acc, ovr, fcs, len};
    @(negedge clk_i);
    q_rx = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/esc_stat_counters_tb.sv
// Self-checking testbench of the statistics counter bank
`timescale 1ns/100ps
`default_nettype none
module esc_stat_counters_tb;
  import esc_pkg::*;
  logic              clk_i = 1'b0;     // 125 MHz clock
  logic              arst_n_i = 1'b0;  // Reset, active low
  logic [ADDR_W-1:0] addr_i = '0;      // Register address
  logic [DATA_W-1:0] wdata_i = '0;     // Write data
  logic [3:0]        be_i = 4'hF;      // Byte enables
  logic              wr_i = 1'b0;      // Write strobe
  logic              rd_i = 1'b0;      // Read strobe
  logic [DATA_W-1:0] rdata_o;          // Read data
  logic              tx_done, tx_ok, rx_done, rx_acc, rx_ovr, rx_fcs, irq_o;
  logic [COLL_W-1:0] tx_coll;          // Collision count
  logic [2:0]        rx_len;           // Dribble bits
  int                error_cnt = 0;    // Mismatches
  int                checks_done = 0;  // Comparisons
  int                cyc = 0;          // Timeout counter

  always #4 clk_i = ~clk_i;

  esc_mac_model i_mac (.clk_i(clk_i), .tx_done_o(tx_done), .tx_ok_o(tx_ok), .tx_coll_o(tx_coll),
    .rx_done_o(rx_done), .rx_accept_o(rx_acc), .rx_overrun_o(rx_ovr), .rx_fcs_err_o(rx_fcs),
    .rx_len_bits_o(rx_len));

  esc_stat_counters i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .be_i(be_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_done_i(tx_done), .tx_ok_i(tx_ok),
    .tx_coll_i(tx_coll), .rx_done_i(rx_done), .rx_accept_i(rx_acc), .rx_overrun_i(rx_ovr),
    .rx_fcs_err_i(rx_fcs), .rx_len_bits_i(rx_len), .irq_o(irq_o));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read strobe for one cycle, data checked in the following cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [3:0] b, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    be_i <= b;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk_i);
    #1 check({31'h0, irq_o}, {31'h0, exp});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd_reg(8'(4 * i), 4'hF, 32'h0000_0000);
  endtask

  task automatic t_tx_rx();
    i_mac.tx(1'b1, 4'h0);
    i_mac.tx(1'b1, 4'h1);
    i_mac.tx(1'b1, 4'h2);
    i_mac.tx(1'b1, 4'hF);
    i_mac.tx(1'b0, 4'h3);
    i_mac.tx(1'b0, 4'h1);
    i_mac.rx(1'b1, 1'b0, 1'b0, 3'h0);
    i_mac.rx(1'b1, 1'b1, 1'b0, 3'h0);
    i_mac.rx(1'b1, 1'b0, 1'b1, 3'h0);
    i_mac.rx(1'b1, 1'b0, 1'b1, 3'h3);
    i_mac.rx(1'b0, 1'b0, 1'b0, 3'h0);
    repeat (4) @(posedge clk_i);
    rd_reg(OFF_IRQ_STAT, 4'hF, 32'h0000_003F);
    rd_reg(OFF_TX_OK, 4'hC, 32'h0000_0004);
    rd_reg(OFF_TX_OK, 4'hF, 32'h0000_0004);
    rd_reg(OFF_TX_OK, 4'h1, 32'h0000_0000);
    rd_reg(OFF_SCOL, 4'h2, 32'h0000_0001);
    rd_reg(OFF_MCOL, 4'hF, 32'h0000_0002);
    rd_reg(OFF_RX_DROP, 4'hF, 32'h0000_0001);
    rd_reg(OFF_RX_OK, 4'hF, 32'h0000_0001);
    rd_reg(OFF_FCS_ERR, 4'hF, 32'h0000_0001);
    rd_reg(OFF_FCS_ERR, 4'hF, 32'h0000_0000);
  endtask

  task automatic t_irq();
    wr_reg(OFF_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr_reg(OFF_IRQ_MASK, 32'h0000_0000);
    irq_is(1'b0);
    wr_reg(OFF_IRQ_MASK, 32'h0000_0001);
    wr_reg(OFF_IRQ_STAT, 32'h0000_003F);
    irq_is(1'b0);
    rd_reg(OFF_IRQ_STAT, 4'hF, 32'h0000_0000);
    i_mac.rx(1'b1, 1'b1, 1'b0, 3'h0);
    irq_is(1'b1);
    rd_reg(OFF_IRQ_STAT, 4'hF, 32'h0000_0001);
    rd_reg(OFF_RX_DROP, 4'hF, 32'h0000_0001);
  endtask

  task automatic t_debug();
    // direct writes only here, as a test access
    wr_reg(OFF_SCOL, 32'hFFFF_1234);
    rd_reg(OFF_SCOL, 4'hF, 32'h0000_1234);
    wr_reg(OFF_SCOL, 32'h0000_FFFF);
    i_mac.tx(1'b1, 4'h1);
    repeat (4) @(posedge clk_i);
    rd_reg(OFF_SCOL, 4'hF, 32'h0000_0000);
    rd_reg(OFF_TX_OK, 4'hF, 32'h0000_0001);
    wr_reg(8'h20, 32'h0000_5555);
    rd_reg(8'h20, 4'hF, 32'h0000_0000);
  endtask

  task automatic t_coincide();
    // Event lands on the same edge as the clearing read
    // Strobe rises on the edge that takes the status pulse
    i_mac.tx(1'b1, 4'h0);
    rd_reg(OFF_TX_OK, 4'hF, 32'h0000_0000);
    rd_reg(OFF_TX_OK, 4'hF, 32'h0000_0001);
  endtask

  // ****************************************************************
  // Main sequence and timeout
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_tx_rx();
    t_irq();
    t_debug();
    t_coincide();
    close_out();
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
endmodule
`default_nettype wire
